// file: core/pipe_not_ready_event_logic.sv
// Register access over APB was chosen for this implementation.
module pipe_not_ready_event_logic
  import pipe_not_ready_event_pkg::*;
#(
  parameter int NUM_PIPES = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire usb_event_s usb_event,
  output pipe_action_s action,
  output logic irq_n
);
  pipe_cfg_s pipe_cfg [NUM_PIPES];
  logic [1:0] fail_cnt [NUM_PIPES];
  logic [NUM_PIPES-1:0] pipe_not_ready_flags;
  logic [NUM_PIPES-1:0] pipe_buffer_empty_flags;
  logic [NUM_PIPES-1:0] not_ready_enable_mask;
  logic [NUM_PIPES-1:0] buffer_empty_event_enable_mask;
  logic iso_overrun_flag;
  logic iso_crc_error_flag;
  logic [1:0] global_irq_status;

  // bus decode
  logic [9:0] widx;
  logic wr_done;
  logic setup_phase;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic cfg_hit;
  logic [9:0] cfg_off;

  assign widx = paddr[ADDR_W-1:2];
  assign wr_done = psel && penable && pready && pwrite;
  assign setup_phase = psel && !penable;
  assign cfg_off = widx - IDX_PIPE_CFG;
  assign cfg_hit = (widx >= IDX_PIPE_CFG) && (cfg_off < 10'(NUM_PIPES));

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (widx == IDX_NOT_READY_EVENT_STATUS) begin
      next_prdata[NUM_PIPES-1:0] = pipe_not_ready_flags;
    end else if (widx == IDX_BUFFER_EMPTY_EVENT_STATUS) begin
      next_prdata[NUM_PIPES-1:0] = pipe_buffer_empty_flags;
    end else if (widx == IDX_FRAME) begin
      next_prdata[FRAME_ISO_OVERRUN_FLAG_BIT] = iso_overrun_flag;
      next_prdata[FRAME_ISO_CRC_ERROR_FLAG_BIT] = iso_crc_error_flag;
    end else if (widx == IDX_NOT_READY_EVENT_MASK) begin
      next_prdata[NUM_PIPES-1:0] = not_ready_enable_mask;
      next_prdata[16 +: NUM_PIPES] = buffer_empty_event_enable_mask;
    end else if (widx == IDX_GLOBAL_STATUS) begin
      next_prdata[GSTAT_NOT_READY_EVENT_BIT] = global_irq_status[0];
      next_prdata[GSTAT_BUFFER_EMPTY_EVENT_BIT] = global_irq_status[1];
    end else if (cfg_hit) begin
      next_prdata[5:0] = pipe_cfg[cfg_off[3:0]];
    end else begin
      next_pslverr = 1'b1;
    end
  end

  // answer: ready in the first access cycle, data captured in setup
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_phase;
      if (setup_phase) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_pslverr;
      end
    end
  end

  // event decode
  usb_event_s ev;
  pipe_cfg_s cur;
  logic ev_ok;
  logic host_split;
  logic is_iso;
  logic fail_third;
  logic a_not_ready_event;
  logic a_iso_overrun_flag;
  logic a_iso_crc_error_flag;
  logic a_nak_sel;
  logic a_stall_sel;
  logic a_clr_cs;
  logic a_zlp;
  logic a_nak_hs;
  logic a_discard;
  logic a_buffer_empty_event;
  logic a_fail_inc;
  logic a_fail_clr;

  assign ev = usb_event;
  assign ev_ok = ev.valid && (ev.pipe < 4'(NUM_PIPES));
  assign cur = ev_ok ? pipe_cfg[ev.pipe] : '0;
  assign host_split = ev.host && ev.split && !ev.setup;
  assign is_iso = cur.xtype == XT_ISO;
  assign fail_third = ev_ok ? (fail_cnt[ev.pipe] == FAIL_LIMIT_M1) : 1'b0;

  always_comb begin
    a_not_ready_event = 1'b0;
    a_iso_overrun_flag = 1'b0;
    a_iso_crc_error_flag = 1'b0;
    a_nak_sel = 1'b0;
    a_stall_sel = 1'b0;
    a_clr_cs = 1'b0;
    a_zlp = 1'b0;
    a_nak_hs = 1'b0;
    a_discard = 1'b0;
    a_buffer_empty_event = 1'b0;
    a_fail_inc = 1'b0;
    a_fail_clr = 1'b0;
    if (ev_ok) begin
      case (ev.kind)
        EV_OUT_TIME_EMPTY: begin
          if (host_split && cur.tx && is_iso && !ev.csplit) begin
            a_not_ready_event = 1'b1;
            a_iso_overrun_flag = 1'b1;
            a_zlp = 1'b1;
          end
        end
        EV_IN_TIME_FULL: begin
          if (host_split && !cur.tx && is_iso) begin
            a_not_ready_event = 1'b1;
            a_iso_overrun_flag = 1'b1;
            a_discard = 1'b1;
          end
        end
        EV_HUB_FAIL: begin
          if (host_split) begin
            a_fail_inc = !fail_third;
            a_fail_clr = fail_third;
            if (fail_third && cur.tx && !is_iso) begin
              a_not_ready_event = 1'b1;
              a_nak_sel = 1'b1;
              a_clr_cs = ev.csplit;
            end else if (fail_third && !cur.tx) begin
              if (cur.xtype == XT_BULK || cur.xtype == XT_CTRL) begin
                a_not_ready_event = 1'b1;
                a_nak_sel = 1'b1;
                a_clr_cs = ev.csplit;
              end else if (ev.csplit && cur.xtype == XT_INTR) begin
                a_not_ready_event = 1'b1;
                a_nak_sel = 1'b1;
                a_clr_cs = 1'b1;
              end else if (ev.csplit) begin
                a_iso_crc_error_flag = 1'b1;
                a_clr_cs = 1'b1;
              end
            end
          end
        end
        EV_HANDSHAKE_OK: a_fail_clr = 1'b1;
        EV_STALL: begin
          if (host_split && ev.csplit && (cur.tx || !is_iso)) begin
            a_not_ready_event = 1'b1;
            a_stall_sel = 1'b1;
            a_clr_cs = 1'b1;
            a_fail_clr = 1'b1;
          end
        end
        EV_NYET: begin
          if (host_split && ev.csplit && ev.uframe == UFRAME_LAST) begin
            if (cur.tx && cur.xtype == XT_INTR) begin
              a_not_ready_event = 1'b1;
              a_clr_cs = 1'b1;
            end else if (!cur.tx && (is_iso || cur.xtype == XT_INTR)) begin
              a_not_ready_event = 1'b1;
              a_iso_crc_error_flag = 1'b1;
              a_clr_cs = 1'b1;
            end
          end
        end
        EV_PER_IN_EMPTY: begin
          if (!ev.host && cur.tx && cur.resp == RESP_BUF) begin
            a_not_ready_event = 1'b1;
            a_zlp = is_iso;
            a_iso_overrun_flag = is_iso;
          end
        end
        EV_PER_OUT_FULL: begin
          if (!ev.host && !cur.tx && cur.resp == RESP_BUF) begin
            if (is_iso) begin
              a_not_ready_event = 1'b1;
              a_iso_overrun_flag = 1'b1;
            end else begin
              a_nak_hs = 1'b1;
              a_not_ready_event = !ev.toggle_mismatch && !ev.data_error;
            end
          end
        end
        EV_PER_PING_FULL: begin
          if (!ev.host && !cur.tx && cur.resp == RESP_BUF) begin
            a_not_ready_event = 1'b1;
          end
        end
        EV_ISO_MISSED: begin
          if (!ev.host && is_iso && cur.resp == RESP_BUF) begin
            a_not_ready_event = 1'b1;
          end
        end
        EV_BUF_EMPTY: a_buffer_empty_event = 1'b1;
        default: a_not_ready_event = 1'b0;
      endcase
    end
  end

  // per-pipe state
  for (genvar i = 0; i < NUM_PIPES; i++) begin : g_pipe
    logic hit;
    logic cfg_wr;
    assign hit = ev_ok && (ev.pipe == 4'(i));
    assign cfg_wr = wr_done && cfg_hit && (cfg_off == 10'(i));

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pipe_cfg[i] <= '0;
      end else begin
        if (cfg_wr) begin
          pipe_cfg[i] <= pipe_cfg_s'(pwdata[5:0]);
        end
        if (hit && a_stall_sel) begin
          pipe_cfg[i].resp <= RESP_STALL;
        end else if (hit && a_nak_sel) begin
          pipe_cfg[i].resp <= RESP_NAK;
        end
        if (hit && a_clr_cs) begin
          pipe_cfg[i].cs_pending <= 1'b0;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        fail_cnt[i] <= 2'h0;
      end else if (hit && a_fail_clr) begin
        fail_cnt[i] <= 2'h0;
      end else if (hit && a_fail_inc) begin
        fail_cnt[i] <= fail_cnt[i] + 2'h1;
      end
    end

    // flag writes: zero clears, one keeps; a hardware set in the same cycle wins
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pipe_not_ready_flags[i] <= 1'b0;
      end else if (hit && a_not_ready_event && pipe_cfg[i].resp == RESP_BUF) begin
        pipe_not_ready_flags[i] <= 1'b1;
      end else if (wr_done && widx == IDX_NOT_READY_EVENT_STATUS && !pwdata[i]) begin
        pipe_not_ready_flags[i] <= 1'b0;
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pipe_buffer_empty_flags[i] <= 1'b0;
      end else if (hit && a_buffer_empty_event) begin
        pipe_buffer_empty_flags[i] <= 1'b1;
      end else if (wr_done && widx == IDX_BUFFER_EMPTY_EVENT_STATUS && !pwdata[i]) begin
        pipe_buffer_empty_flags[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      iso_overrun_flag <= 1'b0;
      iso_crc_error_flag <= 1'b0;
    end else begin
      if (a_iso_overrun_flag) begin
        iso_overrun_flag <= 1'b1;
      end else if (wr_done && widx == IDX_FRAME && !pwdata[FRAME_ISO_OVERRUN_FLAG_BIT]) begin
        iso_overrun_flag <= 1'b0;
      end
      if (a_iso_crc_error_flag) begin
        iso_crc_error_flag <= 1'b1;
      end else if (wr_done && widx == IDX_FRAME && !pwdata[FRAME_ISO_CRC_ERROR_FLAG_BIT]) begin
        iso_crc_error_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      not_ready_enable_mask <= '0;
      buffer_empty_event_enable_mask <= '0;
    end else if (wr_done && widx == IDX_NOT_READY_EVENT_MASK) begin
      not_ready_enable_mask <= pwdata[NUM_PIPES-1:0];
      buffer_empty_event_enable_mask <= pwdata[16 +: NUM_PIPES];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      global_irq_status <= 2'h0;
      irq_n <= 1'b1;
    end else begin
      global_irq_status[0] <= |(pipe_not_ready_flags & not_ready_enable_mask);
      global_irq_status[1] <= |(pipe_buffer_empty_flags & buffer_empty_event_enable_mask);
      irq_n <= !(|global_irq_status);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      action <= '0;
    end else begin
      action.not_ready_event <= a_not_ready_event;
      action.pipe <= ev.pipe;
      action.send_zlp <= a_zlp;
      action.send_nak <= a_nak_hs;
      action.discard <= a_discard;
    end
  end

  // checks
  a_stall_code: assert property (@(posedge clk) disable iff (!rst_n)
    (ev_ok && ev.kind == EV_STALL && host_split && ev.csplit && cur.tx) |=>
    (pipe_cfg[$past(ev.pipe)].resp == RESP_STALL && !pipe_cfg[$past(ev.pipe)].cs_pending))
    else $error("stall on complete-split did not select stall");
  a_third_fail_nak: assert property (@(posedge clk) disable iff (!rst_n)
    (ev_ok && ev.kind == EV_HUB_FAIL && host_split && cur.tx && !is_iso && fail_third) |=>
    (pipe_cfg[$past(ev.pipe)].resp == RESP_NAK && fail_cnt[$past(ev.pipe)] == 2'h0))
    else $error("third hub failure did not select nak");
  a_early_fail_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (ev_ok && ev.kind == EV_HUB_FAIL && host_split && !fail_third) |=> !action.not_ready_event)
    else $error("not-ready raised before third failure");
  a_nyet_keeps_resp: assert property (@(posedge clk) disable iff (!rst_n)
    (ev_ok && ev.kind == EV_NYET && host_split && ev.csplit && ev.uframe == UFRAME_LAST
     && cur.tx && cur.xtype == XT_INTR && !(wr_done && cfg_hit)) |=>
    (pipe_cfg[$past(ev.pipe)].resp == $past(cur.resp) && action.not_ready_event))
    else $error("nyet at last microframe mishandled");
  a_iso_fail_iso_crc_error_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (ev_ok && ev.kind == EV_HUB_FAIL && host_split && ev.csplit && !cur.tx && is_iso && fail_third)
    |=> (iso_crc_error_flag && !action.not_ready_event))
    else $error("iso complete-split failure did not set crc error");
  a_toggle_no_not_ready_event: assert property (@(posedge clk) disable iff (!rst_n)
    (ev_ok && ev.kind == EV_PER_OUT_FULL && !ev.host && !is_iso && (ev.toggle_mismatch || ev.data_error))
    |=> !action.not_ready_event)
    else $error("not-ready raised for retransmission or bad packet");
  a_per_out_nak: assert property (@(posedge clk) disable iff (!rst_n)
    (ev_ok && ev.kind == EV_PER_OUT_FULL && !ev.host && !cur.tx && !is_iso && cur.resp == RESP_BUF)
    |=> action.send_nak)
    else $error("full non-iso receive did not answer nak");
  a_buffer_empty_event_w0c: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_done && widx == IDX_BUFFER_EMPTY_EVENT_STATUS && !(ev_ok && a_buffer_empty_event)) |=>
    (pipe_buffer_empty_flags == ($past(pipe_buffer_empty_flags) & $past(pwdata[NUM_PIPES-1:0]))))
    else $error("buffer-empty write did not clear by zero");
  a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
    (|(pipe_not_ready_flags & not_ready_enable_mask)) |-> ##2 !irq_n)
    else $error("enabled not-ready flag did not raise interrupt");
  a_iso_zlp_iso_overrun_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (ev_ok && ev.kind == EV_OUT_TIME_EMPTY && host_split && !ev.csplit && cur.tx && is_iso)
    |=> (action.send_zlp && iso_overrun_flag))
    else $error("iso empty out timing did not send zlp");

  c_stall: cover property (@(posedge clk) disable iff (!rst_n) ev_ok && a_stall_sel);
  c_third_fail: cover property (@(posedge clk) disable iff (!rst_n) ev_ok && a_nak_sel);
  c_per_nak: cover property (@(posedge clk) disable iff (!rst_n) a_nak_hs);
  c_irq: cover property (@(posedge clk) disable iff (!rst_n) !irq_n);
endmodule

// file: core/pipe_not_ready_event_pkg.sv
package pipe_not_ready_event_pkg;
  localparam int ADDR_W = 12;
  // printed offsets are register indexes; byte address is four times the index
  localparam logic [9:0] IDX_GLOBAL_STATUS = 10'h040;
  localparam logic [9:0] IDX_NOT_READY_EVENT_MASK = 10'h042;
  localparam logic [9:0] IDX_NOT_READY_EVENT_STATUS = 10'h048;
  localparam logic [9:0] IDX_BUFFER_EMPTY_EVENT_STATUS = 10'h04A;
  localparam logic [9:0] IDX_FRAME = 10'h04C;
  localparam logic [9:0] IDX_PIPE_CFG = 10'h068;
  localparam int FRAME_ISO_OVERRUN_FLAG_BIT = 15;
  localparam int FRAME_ISO_CRC_ERROR_FLAG_BIT = 14;
  localparam int GSTAT_NOT_READY_EVENT_BIT = 9;
  localparam int GSTAT_BUFFER_EMPTY_EVENT_BIT = 10;
  localparam logic [1:0] RESP_NAK = 2'h0;
  localparam logic [1:0] RESP_BUF = 2'h1;
  localparam logic [1:0] RESP_STALL = 2'h3;
  localparam logic [1:0] FAIL_LIMIT_M1 = 2'h2;
  localparam logic [2:0] UFRAME_LAST = 3'h4;

  typedef enum logic [1:0] {
    XT_CTRL = 2'b00,
    XT_ISO = 2'b01,
    XT_BULK = 2'b10,
    XT_INTR = 2'b11
  } xfer_type_e;

  typedef enum logic [3:0] {
    EV_NONE = 4'b0000,
    EV_OUT_TIME_EMPTY = 4'b0001,
    EV_IN_TIME_FULL = 4'b0010,
    EV_HUB_FAIL = 4'b0011,
    EV_HANDSHAKE_OK = 4'b0100,
    EV_STALL = 4'b0101,
    EV_NYET = 4'b0110,
    EV_PER_IN_EMPTY = 4'b0111,
    EV_PER_OUT_FULL = 4'b1000,
    EV_PER_PING_FULL = 4'b1001,
    EV_ISO_MISSED = 4'b1010,
    EV_BUF_EMPTY = 4'b1011
  } ev_kind_e;

  // cfg register layout: [1:0] response select, [3:2] type, [4] transmit, [5] split pending
  typedef struct packed {
    logic cs_pending;
    logic tx;
    xfer_type_e xtype;
    logic [1:0] resp;
  } pipe_cfg_s;

  typedef struct packed {
    logic valid;
    ev_kind_e kind;
    logic [3:0] pipe;
    logic host;
    logic split;
    logic csplit;
    logic setup;
    logic toggle_mismatch;
    logic data_error;
    logic [2:0] uframe;
  } usb_event_s;

  typedef struct packed {
    logic not_ready_event;
    logic [3:0] pipe;
    logic send_zlp;
    logic send_nak;
    logic discard;
  } pipe_action_s;
endpackage

// file: testbench/usb_far_side.sv
module usb_far_side
  import pipe_not_ready_event_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire usb_event_s req,
  output usb_event_s usb_event
);
  timeunit 1ns;
  timeprecision 1ps;

  // one-cycle event per request; between events the fields carry inverted junk with valid low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      usb_event <= '0;
    end else if (go) begin
      usb_event <= req;
    end else begin
      usb_event <= usb_event_s'({1'b0, ~req[$bits(usb_event_s)-2:0]});
    end
  end
endmodule

// file: testbench/tb_usb_pipe_not_ready_event_logic.sv
module tb_usb_pipe_not_ready_event_logic
  import pipe_not_ready_event_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [5:0] cfg;
    ev_kind_e kind;
    logic [1:0] hc;
    logic [2:0] uf;
    logic [1:0] er;
    logic [1:0] reps;
    logic [3:0] care;
    logic [3:0] act;
    logic [5:0] xcfg;
    logic [2:0] res;
  } row_s;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq_n;
  logic go = 1'b0;
  logic ev_setup = 1'b0;
  usb_event_s req = '0;
  usb_event_s usb_event;
  pipe_action_s action;
  pipe_action_s act_seen;
  logic [3:0] act4;
  logic [31:0] rd;
  logic err;
  row_s r;
  logic [3:0] p;
  int miscompares = 0;
  int samples_checked = 0;

  // cfg, kind, {host,csplit}, uframe, {toggle,data err}, count, care, {nre,zlp,nak,discard}, cfg after,
  // {flag,overrun,crc}
  row_s rows [21] = '{
    '{6'h15, EV_OUT_TIME_EMPTY, 2'h2, 3'h0, 2'h0, 2'h1, 4'hF, 4'hC, 6'h15, 3'h6},
    '{6'h39, EV_HUB_FAIL, 2'h3, 3'h0, 2'h0, 2'h3, 4'hF, 4'h8, 6'h18, 3'h4},
    '{6'h3D, EV_STALL, 2'h3, 3'h0, 2'h0, 2'h1, 4'hF, 4'h8, 6'h1F, 3'h4},
    '{6'h3D, EV_NYET, 2'h3, 3'h4, 2'h0, 2'h1, 4'hF, 4'h8, 6'h1D, 3'h4},
    '{6'h05, EV_IN_TIME_FULL, 2'h2, 3'h0, 2'h0, 2'h1, 4'hF, 4'h9, 6'h05, 3'h6},
    '{6'h29, EV_HUB_FAIL, 2'h3, 3'h0, 2'h0, 2'h3, 4'hF, 4'h8, 6'h08, 3'h4},
    '{6'h2D, EV_HUB_FAIL, 2'h3, 3'h0, 2'h0, 2'h3, 4'hF, 4'h8, 6'h0C, 3'h4},
    '{6'h25, EV_HUB_FAIL, 2'h3, 3'h0, 2'h0, 2'h3, 4'h6, 4'h0, 6'h05, 3'h1},
    '{6'h29, EV_STALL, 2'h3, 3'h0, 2'h0, 2'h1, 4'hF, 4'h8, 6'h0B, 3'h4},
    '{6'h25, EV_NYET, 2'h3, 3'h4, 2'h0, 2'h1, 4'hF, 4'h8, 6'h05, 3'h5},
    '{6'h15, EV_PER_IN_EMPTY, 2'h0, 3'h0, 2'h0, 2'h1, 4'hF, 4'hC, 6'h15, 3'h6},
    '{6'h19, EV_PER_IN_EMPTY, 2'h0, 3'h0, 2'h0, 2'h1, 4'hF, 4'h8, 6'h19, 3'h4},
    '{6'h05, EV_PER_OUT_FULL, 2'h0, 3'h0, 2'h0, 2'h1, 4'hE, 4'h8, 6'h05, 3'h6},
    '{6'h09, EV_PER_OUT_FULL, 2'h0, 3'h0, 2'h0, 2'h1, 4'hE, 4'hA, 6'h09, 3'h4},
    '{6'h09, EV_PER_OUT_FULL, 2'h0, 3'h0, 2'h2, 2'h1, 4'h8, 4'h0, 6'h09, 3'h0},
    '{6'h09, EV_PER_OUT_FULL, 2'h0, 3'h0, 2'h1, 2'h1, 4'h8, 4'h0, 6'h09, 3'h0},
    '{6'h09, EV_PER_PING_FULL, 2'h0, 3'h0, 2'h0, 2'h1, 4'hC, 4'h8, 6'h09, 3'h4},
    '{6'h05, EV_ISO_MISSED, 2'h0, 3'h0, 2'h0, 2'h1, 4'hE, 4'h8, 6'h05, 3'h4},
    '{6'h08, EV_PER_OUT_FULL, 2'h0, 3'h0, 2'h0, 2'h1, 4'h0, 4'h0, 6'h08, 3'h0},
    '{6'h25, EV_NYET, 2'h3, 3'h3, 2'h0, 2'h1, 4'h8, 4'h0, 6'h25, 3'h0},
    '{6'h39, EV_HUB_FAIL, 2'h3, 3'h0, 2'h0, 2'h2, 4'h8, 4'h0, 6'h39, 3'h0}
  };

  always #4 clk = ~clk;

  usb_far_side i_far (.clk(clk), .rst_n(rst_n), .go(go), .req(req), .usb_event(usb_event));

  pipe_not_ready_event_logic i_dut (
    .clk(clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .usb_event(usb_event),
    .action(action),
    .irq_n(irq_n)
  );

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input string name, input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(name, exp, rd);
  endtask

  task automatic ev(input ev_kind_e k, input logic [3:0] pp, input logic [1:0] hc, input logic [2:0] uf,
                    input logic [1:0] er);
    usb_event_s e;
    e = '0;
    e.valid = 1'b1;
    e.kind = k;
    e.pipe = pp;
    e.host = hc[1];
    e.split = hc[1];
    e.csplit = hc[0];
    e.uframe = uf;
    e.toggle_mismatch = er[1];
    e.data_error = er[0];
    e.setup = ev_setup;
    req <= e;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    act_seen = action;
    act4 = {action.not_ready_event, action.send_zlp, action.send_nak, action.discard};
  endtask

  task automatic results;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 21; i++) begin
      r = rows[i];
      p = 4'(i % 10);
      apb(1'b1, IDX_PIPE_CFG + 10'(p), {26'h0, r.cfg});
      apb(1'b1, IDX_NOT_READY_EVENT_STATUS, 32'h0);
      apb(1'b1, IDX_FRAME, 32'h0);
      repeat (r.reps) ev(r.kind, p, r.hc, r.uf, r.er);
      chk("action", {28'h0, r.act & r.care}, {28'h0, act4 & r.care});
      if (r.act[3]) chk("action pipe", {28'h0, p}, {28'h0, act_seen.pipe});
      rchk("pipe cfg", IDX_PIPE_CFG + 10'(p), {26'h0, r.xcfg});
      rchk("not ready status", IDX_NOT_READY_EVENT_STATUS, {31'h0, r.res[2]} << p);
      apb(1'b0, IDX_FRAME, 32'h0);
      chk("iso flags", {30'h0, r.res[1:0]}, {30'h0, rd[15:14]});
    end
    // reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("irq idle", 32'h1, {31'h0, irq_n});
    rchk("cfg after reset", IDX_PIPE_CFG, 32'h0);
    // success in between restarts the failure count
    apb(1'b1, IDX_PIPE_CFG + 10'h6, 32'h29);
    repeat (2) ev(EV_HUB_FAIL, 4'h6, 2'h3, 3'h0, 2'h0);
    ev(EV_HANDSHAKE_OK, 4'h6, 2'h3, 3'h0, 2'h0);
    repeat (2) ev(EV_HUB_FAIL, 4'h6, 2'h3, 3'h0, 2'h0);
    rchk("no early trip", IDX_NOT_READY_EVENT_STATUS, 32'h0);
    ev(EV_HUB_FAIL, 4'h6, 2'h3, 3'h0, 2'h0);
    rchk("third trip", IDX_NOT_READY_EVENT_STATUS, 32'h40);
    // setup transactions never count toward the split failure trip
    apb(1'b1, IDX_PIPE_CFG + 10'h4, 32'h29);
    ev_setup = 1'b1;
    repeat (3) ev(EV_HUB_FAIL, 4'h4, 2'h3, 3'h0, 2'h0);
    ev_setup = 1'b0;
    rchk("setup ignored", IDX_PIPE_CFG + 10'h4, 32'h29);
    // enabled flag raises the interrupt, clearing drops it, masked flag stays quiet
    apb(1'b1, IDX_PIPE_CFG + 10'h3, 32'h09);
    apb(1'b1, IDX_NOT_READY_EVENT_STATUS, 32'h0);
    apb(1'b1, IDX_NOT_READY_EVENT_MASK, 32'h8);
    ev(EV_PER_OUT_FULL, 4'h3, 2'h0, 3'h0, 2'h0);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq_n});
    apb(1'b0, IDX_GLOBAL_STATUS, 32'h0);
    chk("global not ready", 32'h1, {31'h0, rd[GSTAT_NOT_READY_EVENT_BIT]});
    apb(1'b1, IDX_NOT_READY_EVENT_STATUS, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq released", 32'h1, {31'h0, irq_n});
    apb(1'b1, IDX_NOT_READY_EVENT_MASK, 32'h0);
    ev(EV_PER_OUT_FULL, 4'h3, 2'h0, 3'h0, 2'h0);
    repeat (3) @(posedge clk);
    chk("irq masked", 32'h1, {31'h0, irq_n});
    rchk("masked flag", IDX_NOT_READY_EVENT_STATUS, 32'h8);
    // buffer-empty flags, selective clear, out-of-range pipe
    apb(1'b1, IDX_PIPE_CFG + 10'h2, 32'h19);
    apb(1'b1, IDX_PIPE_CFG + 10'h5, 32'h19);
    ev(EV_BUF_EMPTY, 4'h2, 2'h0, 3'h0, 2'h0);
    ev(EV_BUF_EMPTY, 4'h5, 2'h0, 3'h0, 2'h0);
    ev(EV_BUF_EMPTY, 4'hA, 2'h0, 3'h0, 2'h0);
    rchk("empty status", IDX_BUFFER_EMPTY_EVENT_STATUS, 32'h24);
    apb(1'b1, IDX_BUFFER_EMPTY_EVENT_STATUS, 32'hFFFFFFFB);
    rchk("empty cleared", IDX_BUFFER_EMPTY_EVENT_STATUS, 32'h20);
    apb(1'b1, IDX_BUFFER_EMPTY_EVENT_STATUS, 32'hFFFFFFFF);
    rchk("empty kept", IDX_BUFFER_EMPTY_EVENT_STATUS, 32'h20);
    apb(1'b0, 10'h3FF, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    results();
  end
endmodule
